/* File: common/info_rom_pkg.sv */
// constants for the device information store and its serial frame
package info_rom_pkg;

	// ----------------------------------------------------------------
	// command byte layout
	// ----------------------------------------------------------------
	localparam int          OPC_MSB    = 7;
	localparam int          OPC_LSB    = 6;
	localparam int          ADDR_MSB   = 5;
	localparam logic [1:0]  OPC_INFO   = 2'h3;

	// ----------------------------------------------------------------
	// information addresses
	// ----------------------------------------------------------------
	localparam logic [5:0]  ADDR_HEADER   = 6'h00;
	localparam logic [5:0]  ADDR_PCODE_LO = 6'h01;
	localparam logic [5:0]  ADDR_PCODE_HI = 6'h02;
	localparam logic [5:0]  ADDR_FRAME_ID = 6'h03;
	localparam logic [5:0]  ADDR_RESERVED = 6'h3f;

	// ----------------------------------------------------------------
	// stored contents
	// ----------------------------------------------------------------
	localparam logic [5:0]  INFO_BYTE_COUNT   = 6'h02;
	localparam logic [7:0]  FRAME_FORMAT_INFO = 8'h02;
	localparam logic [7:0]  EMPTY_BYTE        = 8'h00;
	localparam int          FMT_W16_BIT       = 1;
	localparam int          FMT_BURST_BIT     = 7;

	// ----------------------------------------------------------------
	// frame timing in serial clock pulses
	// ----------------------------------------------------------------
	localparam logic [5:0]  CMD_LAST_EDGE = 6'h07;
	localparam logic [5:0]  CMD_BITS      = 6'h08;
	localparam logic [5:0]  FRAME_BITS    = 6'h10;
	localparam logic [5:0]  NO_PULSES     = 6'h00;
	localparam logic [5:0]  CNT_MAX       = 6'h3f;

endpackage

/* File: common/rom_if.sv */
// lookup request and answer between frame logic and information store
`timescale 1ns/100ps
interface rom_if;
	logic [1:0] opcode;
	logic [5:0] addr;
	logic [7:0] data;

	modport requester (output opcode, output addr, input data);
	modport rom       (input opcode, input addr, output data);
endinterface

/* File: hdl/info_rom_lookup.sv */
// read-only device information store
`timescale 1ns/100ps
module info_rom_lookup import info_rom_pkg::*; #(
	parameter logic [1:0]  FAMILY_CODE  = 2'h2,
	parameter logic [15:0] PRODUCT_CODE = 16'h5a3c
) (
	// lookup port
	rom_if.rom rif
);

	// ----------------------------------------------------------------
	// contents
	// ----------------------------------------------------------------
	always_comb begin
		rif.data = EMPTY_BYTE;
		if (rif.opcode == OPC_INFO) begin
			case (rif.addr)
				ADDR_HEADER:   rif.data = {FAMILY_CODE, INFO_BYTE_COUNT};
				ADDR_PCODE_LO: rif.data = PRODUCT_CODE[7:0];
				ADDR_PCODE_HI: rif.data = PRODUCT_CODE[15:8];
				ADDR_FRAME_ID: rif.data = FRAME_FORMAT_INFO;
				default:       rif.data = EMPTY_BYTE;
			endcase
		end
	end

endmodule

/* File: hdl/spi_device_info_rom.sv */
// serial frame handler with device information readout
`timescale 1ns/100ps
module spi_device_info_rom import info_rom_pkg::*; #(
	parameter logic [1:0]  FAMILY_CODE  = 2'h2,    // arbitrary value
	parameter logic [15:0] PRODUCT_CODE = 16'h5a3c // arbitrary value
) (
	// system
	input  wire logic       CLK_SYS,
	input  wire logic       RST_B,
	// serial link pins
	input  wire logic       CHIP_SELECT_PIN_B,
	input  wire logic       SCLK_PIN,
	input  wire logic       SDI_PIN,
	output logic            SDO_PIN,
	output logic            SDO_OE,
	// ordinary register port
	input  wire logic [7:0] REG_RD_DATA,
	output logic            REG_CMD_STROBE,
	output logic [7:0]      REG_CMD,
	output logic [7:0]      REG_WR_DATA,
	// status
	input  wire logic       FRAME_ERROR_CLR,
	output logic            FRAME_ERROR_BIT,
	output logic            FAIL_SAFE
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0]  cs_sync_q;
	logic [2:0]  sclk_sync_q;
	logic [1:0]  sdi_sync_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			cs_sync_q   <= 3'h7;
			sclk_sync_q <= 3'h0;
			sdi_sync_q  <= 2'h0;
		end else begin
			cs_sync_q   <= {cs_sync_q[1:0], CHIP_SELECT_PIN_B};
			sclk_sync_q <= {sclk_sync_q[1:0], SCLK_PIN};
			sdi_sync_q  <= {sdi_sync_q[0], SDI_PIN};
		end
	end

	logic cs_act;
	logic frame_end;
	logic sclk_rise;
	logic sclk_fall;

	assign cs_act    = !cs_sync_q[1];
	assign frame_end = cs_sync_q[1] && !cs_sync_q[2];
	assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
	assign sclk_fall = !sclk_sync_q[1] && sclk_sync_q[2];

	// ----------------------------------------------------------------
	// pulse counter and receive shifter
	// ----------------------------------------------------------------
	logic [5:0]  bit_cnt_q;
	logic [15:0] rx_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B || !cs_act) begin
			bit_cnt_q <= NO_PULSES;
		end else if (sclk_rise && bit_cnt_q != CNT_MAX) begin
			bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			rx_q <= 16'h0000;
		end else if (cs_act && sclk_rise) begin
			rx_q <= {rx_q[14:0], sdi_sync_q[1]};
		end
	end

	// ----------------------------------------------------------------
	// information lookup on the last command edge
	// ----------------------------------------------------------------
	logic [7:0] cmd_now;
	logic       load_resp;
	logic       info_now;
	rom_if      rif ();

	assign cmd_now    = {rx_q[6:0], sdi_sync_q[1]};
	assign load_resp  = cs_act && sclk_rise && bit_cnt_q == CMD_LAST_EDGE;
	assign info_now   = cmd_now[OPC_MSB:OPC_LSB] == OPC_INFO;
	assign rif.opcode = cmd_now[OPC_MSB:OPC_LSB];
	assign rif.addr   = cmd_now[ADDR_MSB:0];

	info_rom_lookup #(
		.FAMILY_CODE  (FAMILY_CODE),
		.PRODUCT_CODE (PRODUCT_CODE)
	) u_rom (
		.rif (rif)
	);

	// ----------------------------------------------------------------
	// transmit shifter, in-frame answer
	// ----------------------------------------------------------------
	logic [7:0] tx_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B || !cs_act) begin
			tx_q <= EMPTY_BYTE;
		end else if (load_resp) begin
			tx_q <= info_now ? rif.data : REG_RD_DATA;
		end else if (sclk_fall && bit_cnt_q > CMD_BITS) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign SDO_PIN = tx_q[7];
	assign SDO_OE  = cs_act;

	// ----------------------------------------------------------------
	// frame completion
	// ----------------------------------------------------------------
	logic good_frame;
	logic info_frame;
	logic reserved_hit;

	assign good_frame   = bit_cnt_q == FRAME_BITS;
	assign info_frame   = rx_q[15:14] == OPC_INFO;
	assign reserved_hit = info_frame && rx_q[13:8] == ADDR_RESERVED;

	logic fail_safe_q;
	logic frame_err_q;
	logic strobe_q;
	logic [7:0] reg_cmd_q;
	logic [7:0] reg_wr_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			fail_safe_q <= 1'b0;
		end else if (frame_end && good_frame && reserved_hit) begin
			fail_safe_q <= 1'b1;
		end
	end

	// a select with no pulses at all is not a frame error
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			frame_err_q <= 1'b0;
		end else if (frame_end && !good_frame && bit_cnt_q != NO_PULSES) begin
			frame_err_q <= 1'b1;
		end else if (FRAME_ERROR_CLR) begin
			frame_err_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			strobe_q  <= 1'b0;
			reg_cmd_q <= EMPTY_BYTE;
			reg_wr_q  <= EMPTY_BYTE;
		end else begin
			strobe_q <= frame_end && good_frame && !info_frame;
			if (frame_end && good_frame && !info_frame) begin
				reg_cmd_q <= rx_q[15:8];
				reg_wr_q  <= rx_q[7:0];
			end
		end
	end

	assign REG_CMD_STROBE  = strobe_q;
	assign REG_CMD         = reg_cmd_q;
	assign REG_WR_DATA     = reg_wr_q;
	assign FRAME_ERROR_BIT = frame_err_q;
	assign FAIL_SAFE       = fail_safe_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	sequence s_bad_end;
		frame_end && !good_frame && bit_cnt_q != NO_PULSES;
	endsequence

	sequence s_reserved_end;
		frame_end && good_frame && reserved_hit;
	endsequence

	sequence s_info_load(logic [5:0] a);
		load_resp && info_now && cmd_now[ADDR_MSB:0] == a;
	endsequence

	a_fail_safe_entry: assert property (
		s_reserved_end |=> FAIL_SAFE [*2])
		else $error("fail-safe not entered on reserved address");
	a_reg_isolation: assert property (
		load_resp && !info_now |=> SDO_PIN == $past(REG_RD_DATA[7]))
		else $error("ordinary read answered from information store");
	a_header_byte: assert property (
		s_info_load(ADDR_HEADER) |=> tx_q == {FAMILY_CODE, INFO_BYTE_COUNT})
		else $error("header byte wrong");
	a_product_code: assert property (
		s_info_load(ADDR_PCODE_HI) |=> tx_q == PRODUCT_CODE[15:8])
		else $error("product code high byte wrong");
	a_frame_id_byte: assert property (
		s_info_load(ADDR_FRAME_ID) |=> tx_q[FMT_W16_BIT]
			&& !tx_q[FMT_BURST_BIT] && tx_q[7:4] == 4'h0
			&& $onehot(tx_q))
		else $error("frame identification byte wrong");
	a_frame_err_set: assert property (
		s_bad_end |=> FRAME_ERROR_BIT && !REG_CMD_STROBE && !FAIL_SAFE
			|| $past(FAIL_SAFE))
		else $error("bad frame not flagged or not dropped");
	a_in_frame_shift: assert property (
		cs_act && sclk_fall && bit_cnt_q > CMD_BITS
			|=> SDO_PIN == $past(tx_q[6]))
		else $error("answer bit not shifted out");
	a_unlisted_zero: assert property (
		load_resp && info_now && cmd_now[ADDR_MSB:0] > ADDR_FRAME_ID
			|=> tx_q == EMPTY_BYTE ##1 $stable(FAIL_SAFE))
		else $error("unlisted information address not zero");

endmodule

/* File: test/host_model.sv */
// host side serial master model for the information store
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire logic clk_sys,
	// serial link
	input  wire logic sdo,
	output logic      cs_b,
	output logic      sclk,
	output logic      sdi
);
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// n pulses of an 80 ns clock, answer taken in the high phase
	task automatic frame(input logic [15:0] word, input int n,
		output logic [7:0] rx);
		rx = 8'h00;
		cs_b <= 1'b0;
		wait_clk(4);
		for (int i = 0; i < n; i++) begin
			sdi <= (i < 16) ? word[15 - i] : 1'b0;
			wait_clk(4);
			sclk <= 1'b1;
			wait_clk(2);
			if (i >= 8 && i < 16)
				rx = {rx[6:0], sdo};
			wait_clk(2);
			sclk <= 1'b0;
		end
		wait_clk(4);
		cs_b <= 1'b1;
		// input has a pull-down once released
		sdi  <= 1'b0;
		wait_clk(8);
	endtask
endmodule

/* File: test/spi_device_info_rom_bench.sv */
// self-checking bench for the device information store
`timescale 1ns/100ps
module spi_device_info_rom_bench;
	import info_rom_pkg::*;
	localparam logic [1:0]  FAMILY_FIELD   = 2'h2;     // arbitrary value
	localparam logic [15:0] PCODE = 16'hc3a6; // arbitrary value
	logic       clk_sys, rst_b, cs_b, sclk, sdi, sdo, sdo_oe;
	logic       strobe, fe_clr, fe, fail_safe, oe_mid;
	logic [7:0] reg_rd_data, reg_cmd, reg_wr_data, rx;
	int         miscompares = 0;
	int         checked = 0;
	int         strobes = 0;

	spi_device_info_rom #(.FAMILY_CODE(FAMILY_FIELD), .PRODUCT_CODE(PCODE))
		i_spi_device_info_rom (.CLK_SYS(clk_sys), .RST_B(rst_b),
		.CHIP_SELECT_PIN_B(cs_b), .SCLK_PIN(sclk), .SDI_PIN(sdi),
		.SDO_PIN(sdo), .SDO_OE(sdo_oe), .REG_RD_DATA(reg_rd_data),
		.REG_CMD_STROBE(strobe), .REG_CMD(reg_cmd),
		.REG_WR_DATA(reg_wr_data), .FRAME_ERROR_CLR(fe_clr),
		.FRAME_ERROR_BIT(fe), .FAIL_SAFE(fail_safe));
	host_model i_host_model (.clk_sys(clk_sys), .sdo(sdo), .cs_b(cs_b),
		.sclk(sclk), .sdi(sdi));

	// ------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------
	always @(posedge clk_sys)
		if (strobe === 1'b1)
			strobes <= strobes + 1;

	// output enable as seen while the serial clock is high
	always @(posedge clk_sys)
		if (sclk === 1'b1)
			oe_mid <= sdo_oe;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [7:0] info_exp(input logic [5:0] a);
		case (a)
			6'h00: return {FAMILY_FIELD, 6'h02};
			6'h01: return PCODE[7:0];
			6'h02: return PCODE[15:8];
			6'h03: return 8'h02;
			default: return 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic info_reads;
		logic [5:0] a [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h3e};
		int         s0;
		logic [7:0] e;
		s0 = strobes;
		foreach (a[k]) begin
			i_host_model.frame({OPC_INFO, a[k], 8'h00}, 16, rx);
			e = info_exp(a[k]);
			check(rx, e);
		end
		check({7'h0, oe_mid}, 8'h01);
		check({7'h0, sdo_oe}, 8'h00);
		check(8'(strobes - s0), 8'h00);
		check({7'h0, fail_safe}, 8'h00);
		$display("info reads done");
	endtask

	task automatic ordinary;
		int s0;
		for (int op = 0; op < 3; op++) begin
			s0 = strobes;
			reg_rd_data <= 8'ha6 ^ 8'(op);
			i_host_model.frame({2'(op), 6'h03, 8'h55}, 16, rx);
			check(rx, 8'ha6 ^ 8'(op));
			check(reg_cmd, {2'(op), 6'h03});
			check(reg_wr_data, 8'h55);
			check(8'(strobes - s0), 8'h01);
		end
		$display("ordinary commands done");
	endtask

	task automatic bad_counts;
		int n [5] = '{0, 8, 17, 24, 32};
		int s0;
		foreach (n[k]) begin
			s0 = strobes;
			i_host_model.frame(16'h4155, n[k], rx);
			check({7'h0, fe}, {7'h0, n[k] != 0});
			check(8'(strobes - s0), 8'h00);
			fe_clr <= 1'b1;
			@(posedge clk_sys);
			fe_clr <= 1'b0;
			@(posedge clk_sys);
			check({7'h0, fe}, 8'h00);
		end
		$display("frame length errors done");
	endtask

	task automatic fail_safe_entry;
		i_host_model.frame({OPC_INFO, 6'h3f, 8'h00}, 15, rx);
		check({7'h0, fail_safe}, 8'h00);
		i_host_model.frame({OPC_INFO, 6'h3f, 8'h00}, 16, rx);
		check({7'h0, fail_safe}, 8'h01);
		i_host_model.frame({OPC_INFO, 6'h03, 8'h00}, 16, rx);
		check(rx, 8'h02);
		check({7'h0, fail_safe}, 8'h01);
		$display("fail-safe entry done");
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#1000000;
		miscompares++;
		end_of_test;
	end

	initial begin
		rst_b       = 1'b0;
		fe_clr      = 1'b0;
		reg_rd_data = 8'h00;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		info_reads;
		ordinary;
		bad_counts;
		fail_safe_entry;
		end_of_test;
	end
endmodule
